// file: smri_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module smri_ctrl_model
	import smri_pkg::*;
#(
	parameter int WAIT_CYC = 2000
)
(
	// clock
	input wire logic clk,
	// command and data pins
	output logic cke,
	output logic csN,
	output logic rasN,
	output logic casN,
	output logic weN,
	output logic [1:0] dqm,
	output logic [11:0] addr,
	output logic [15:0] dqIn
);
	initial begin
		cke = 1'b1;
		csN = 1'b1;
		{rasN, casN, weN} = CMD_NOP;
		dqm = 2'h3;
		addr = 12'h000;
		dqIn = 16'hD000;
	end
	// write data changes every cycle
	always @(posedge clk) begin
		dqIn <= dqIn + 16'h0001;
	end
	////////////////////////////////////////////////////////////
	// one command cycle, then deselect with inverted address
	task automatic issue(input logic [2:0] c, input logic [11:0] a);
		@(posedge clk);
		csN <= 1'b0;
		{rasN, casN, weN} <= c;
		addr <= a;
		@(posedge clk);
		csN <= 1'b1;
		{rasN, casN, weN} <= CMD_NOP;
		addr <= ~a;
	endtask : issue
	// callers precharge first; only defined write modes used
	task automatic load(input logic [11:0] op);
		issue(CMD_MODE, op);
		@(posedge clk);
	endtask : load
	task automatic init(input logic modeFirst, input logic [11:0] op);
		dqm <= 2'h3;
		repeat (WAIT_CYC) @(posedge clk);
		issue(CMD_PRE, 12'h400);
		if (modeFirst) begin
			load(op);
		end
		issue(CMD_REF, 12'h000);
		issue(CMD_REF, 12'h000);
		if (!modeFirst) begin
			load(op);
		end
		dqm <= 2'h0;
	endtask : init
endmodule : smri_ctrl_model
`default_nettype wire

// file: smri_pkg.sv
`default_nettype none
package smri_pkg;
	// command pin patterns {rasN, casN, weN}
	localparam logic [2:0] CMD_NOP = 3'h7;
	localparam logic [2:0] CMD_STOP = 3'h6;
	localparam logic [2:0] CMD_READ = 3'h5;
	localparam logic [2:0] CMD_WRITE = 3'h4;
	localparam logic [2:0] CMD_ACT = 3'h3;
	localparam logic [2:0] CMD_PRE = 3'h2;
	localparam logic [2:0] CMD_REF = 3'h1;
	localparam logic [2:0] CMD_MODE = 3'h0;
	// address bit roles
	localparam int ADDR_AP = 10;
	localparam int ADDR_BANK = 11;
	localparam int COL_W = 8;
	localparam int ROW_W = 11;
	// operation code fields
	localparam int OP_BL_LSB = 0;
	localparam int OP_BT = 3;
	localparam int OP_LAT_LSB = 4;
	localparam int OP_WM_LSB = 9;
	localparam logic [2:0] BL_1 = 3'h0;
	localparam logic [2:0] BL_2 = 3'h1;
	localparam logic [2:0] BL_4 = 3'h2;
	localparam logic [2:0] BL_8 = 3'h3;
	localparam logic [2:0] BL_PAGE = 3'h7;
	localparam logic [2:0] LAT_2 = 3'h2;
	localparam logic [2:0] LAT_3 = 3'h3;
	localparam logic [2:0] WM_BURST = 3'h0;
	localparam logic [2:0] WM_SINGLE = 3'h1;
	localparam logic [8:0] PAGE_LEN = 9'h100;
	localparam int LAT_MAX = 3;
	localparam int MIN_REFRESH = 2;
	// register map, word aligned
	localparam logic [3:0] REG_STATUS = 4'h0;
	localparam logic [3:0] REG_CTRL = 4'h4;
	localparam logic [11:0] OPCODE_RST = 12'h000;
	localparam logic CTRL_RST = 1'b0;
	// per bank state, one-hot
	typedef enum logic [5:0] {
		BANK_IDLE = 6'h01,
		BANK_ACTIVE = 6'h02,
		BANK_READ = 6'h04,
		BANK_WRITE = 6'h08,
		BANK_READ_AP = 6'h10,
		BANK_WRITE_AP = 6'h20
	} smri_bank_t;
	// initialization progress, one-hot
	typedef enum logic [2:0] {
		INIT_WAIT_PALL = 3'h1,
		INIT_SETUP = 3'h2,
		INIT_READY = 3'h4
	} smri_init_t;
endpackage : smri_pkg
`default_nettype wire

// file: smri_sdram_mode.sv
// What this block does
// - each bank tracked as idle, active, read, write, or their auto-precharge forms
// - column address bits 8 and 9 ignored on reads and writes
// - mode load may come before the refreshes; both orders accepted
// - mode load captures address pins 0 to 11 as the operation code
// - first read data appears read latency clocks after the read, 2 or 3
// - burst length 1, 2, 4, 8 or full page from bits 2..0
// - one start address, following columns generated internally until done
// - bit 3 picks sequential or interleaved burst order for lengths 2, 4 and 8; full page is always sequential
// - write mode 000 gives burst writes of programmed length
// - first write data taken with the write command itself
// - write mode 001 writes only the addressed column
// - full page burst moves 256 items wrapping through the row
// - address bit 10 is auto-precharge, bit 11 picks the bank
`timescale 1ns/1ps
`default_nettype none
module smri_sdram_mode
	import smri_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// command pins
	input wire logic cke,
	input wire logic csN,
	input wire logic rasN,
	input wire logic casN,
	input wire logic weN,
	input wire logic [1:0] dqm,
	input wire logic [11:0] addr,
	// data pins
	input wire logic [15:0] dqIn,
	output logic [15:0] dqOut,
	output logic dqOe,
	// storage array port
	output logic memRead,
	output logic memWrite,
	output logic memBank,
	output logic [ROW_W-1:0] memRow,
	output logic [COL_W-1:0] memCol,
	output logic [15:0] memWdata,
	output logic [1:0] memByteEn,
	input wire logic [15:0] memRdata,
	// status pins
	output logic initDone,
	output logic cmdIllegal,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o
);
	////////////////////////////////////////////////////////////////////////
	// command decode
	logic cmdOn;
	logic [2:0] cmd;
	logic rwCmd, rdCmd, wrCmd, actCmd, preCmd, refCmd, modeCmd, stopCmd;
	assign cmdOn = cke && !csN;
	assign cmd = {rasN, casN, weN};
	assign rdCmd = cmdOn && cmd == CMD_READ;
	assign wrCmd = cmdOn && cmd == CMD_WRITE;
	assign rwCmd = rdCmd || wrCmd;
	assign actCmd = cmdOn && cmd == CMD_ACT;
	assign preCmd = cmdOn && cmd == CMD_PRE;
	assign refCmd = cmdOn && cmd == CMD_REF;
	assign modeCmd = cmdOn && cmd == CMD_MODE;
	assign stopCmd = cmdOn && cmd == CMD_STOP;

	////////////////////////////////////////////////////////////////////////
	// mode fields
	logic [11:0] opcode;
	logic modeValid;
	logic allIdle;
	logic [2:0] blCode, latCode, wmCode;
	logic interleave, singleWrite;
	assign blCode = opcode[OP_BL_LSB +: 3];
	assign latCode = opcode[OP_LAT_LSB +: 3];
	assign wmCode = opcode[OP_WM_LSB +: 3];
	assign interleave = opcode[OP_BT];
	assign singleWrite = wmCode == WM_SINGLE;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			opcode <= OPCODE_RST;
			modeValid <= 1'b0;
		end else if (modeCmd && allIdle) begin
			opcode <= addr;
			modeValid <= 1'b1;
		end
	end

	function automatic logic [8:0] lenOf(input logic [2:0] code);
		case (code)
			BL_1: lenOf = 9'h001;
			BL_2: lenOf = 9'h002;
			BL_4: lenOf = 9'h004;
			BL_8: lenOf = 9'h008;
			BL_PAGE: lenOf = PAGE_LEN;
			default: lenOf = 9'h001;
		endcase
	endfunction : lenOf

	function automatic logic [7:0] colOf(input logic [7:0] start, input logic [7:0] idx,
		input logic [8:0] len, input logic ilv);
		logic [7:0] mask;
		mask = len[7:0] - 8'h01;
		if (len == PAGE_LEN)
			colOf = start + idx;
		else if (ilv)
			colOf = (start & ~mask) | ((start ^ idx) & mask);
		else
			colOf = (start & ~mask) | ((start + idx) & mask);
	endfunction : colOf

	////////////////////////////////////////////////////////////////////////
	// burst engine
	logic burstActive, burstWrite, burstAp, burstBank;
	logic [7:0] burstStart, burstIdx;
	logic [8:0] burstLen, cmdLen;
	logic lastNow, burstEnd;
	assign cmdLen = (wrCmd && singleWrite) ? 9'h001 : lenOf(blCode);
	assign lastNow = cmdLen == 9'h001;
	assign burstEnd = burstActive && ({1'b0, burstIdx} == burstLen - 9'h001 || stopCmd || rwCmd
		|| (preCmd && (addr[ADDR_AP] || addr[ADDR_BANK] == burstBank)));

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			burstActive <= 1'b0;
			burstWrite <= 1'b0;
			burstAp <= 1'b0;
			burstBank <= 1'b0;
			burstStart <= 8'h00;
			burstIdx <= 8'h00;
			burstLen <= 9'h001;
		end else if (rwCmd) begin
			burstActive <= !lastNow;
			burstWrite <= wrCmd;
			burstAp <= addr[ADDR_AP];
			burstBank <= addr[ADDR_BANK];
			burstStart <= addr[COL_W-1:0];
			burstIdx <= 8'h01;
			burstLen <= cmdLen;
		end else if (burstEnd) begin
			burstActive <= 1'b0;
		end else if (burstActive) begin
			burstIdx <= burstIdx + 8'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// array access, one cycle behind the pins
	logic [ROW_W-1:0] openRow [2];
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			memRead <= 1'b0;
			memWrite <= 1'b0;
			memBank <= 1'b0;
			memCol <= 8'h00;
			memWdata <= 16'h0000;
			memByteEn <= 2'h0;
		end else if (rwCmd) begin
			memRead <= rdCmd;
			memWrite <= wrCmd;
			memBank <= addr[ADDR_BANK];
			memCol <= addr[COL_W-1:0];
			memWdata <= dqIn;
			memByteEn <= ~dqm;
		end else if (burstActive && !burstEnd || burstActive && {1'b0, burstIdx} == burstLen - 9'h001
			&& !stopCmd && !preCmd) begin
			memRead <= !burstWrite;
			memWrite <= burstWrite;
			memBank <= burstBank;
			memCol <= colOf(burstStart, burstIdx, burstLen, interleave);
			memWdata <= dqIn;
			memByteEn <= ~dqm;
		end else begin
			memRead <= 1'b0;
			memWrite <= 1'b0;
		end
	end
	assign memRow = openRow[memBank];

	////////////////////////////////////////////////////////////////////////
	// read latency pipeline
	logic [15:0] rdData [LAT_MAX-1];
	logic [LAT_MAX-2:0] rdValid;
	logic latThree;
	assign latThree = latCode == LAT_3;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rdValid <= '0;
			rdData[0] <= 16'h0000;
			rdData[1] <= 16'h0000;
		end else begin
			rdValid <= {rdValid[0], memRead};
			rdData[0] <= memRdata;
			rdData[1] <= rdData[0];
		end
	end
	assign dqOut = latThree ? rdData[1] : rdData[0];
	assign dqOe = latThree ? rdValid[1] : rdValid[0];

	////////////////////////////////////////////////////////////////////////
	// bank state tracking
	smri_bank_t bankState [2];
	logic [1:0] bankIdle;
	genvar b;
	generate
		for (b = 0; b < 2; b++) begin : g_bank
			logic hit;
			assign hit = addr[ADDR_BANK] == 1'(b);
			assign bankIdle[b] = bankState[b] == BANK_IDLE;
			always_ff @(posedge clk) begin
				if (sys_rst) begin
					bankState[b] <= BANK_IDLE;
					openRow[b] <= '0;
				end else if (preCmd && (addr[ADDR_AP] || hit)) begin
					bankState[b] <= BANK_IDLE;
				end else if (actCmd && hit && bankIdle[b]) begin
					bankState[b] <= BANK_ACTIVE;
					openRow[b] <= addr[ROW_W-1:0];
				end else if (rwCmd && hit && !bankIdle[b]) begin
					if (lastNow)
						bankState[b] <= addr[ADDR_AP] ? BANK_IDLE : BANK_ACTIVE;
					else if (rdCmd)
						bankState[b] <= addr[ADDR_AP] ? BANK_READ_AP : BANK_READ;
					else
						bankState[b] <= addr[ADDR_AP] ? BANK_WRITE_AP : BANK_WRITE;
				end else if (burstEnd && burstBank == 1'(b)) begin
					bankState[b] <= burstAp ? BANK_IDLE : BANK_ACTIVE;
				end
			end
		end
	endgenerate
	assign allIdle = &bankIdle;

	////////////////////////////////////////////////////////////////////////
	// initialization progress and legality
	smri_init_t initState;
	logic [1:0] refCount;
	logic strictInit;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			initState <= INIT_WAIT_PALL;
			refCount <= 2'h0;
		end else begin
			case (initState)
				INIT_WAIT_PALL: if (preCmd && addr[ADDR_AP]) initState <= INIT_SETUP;
				INIT_SETUP: begin
					if (refCmd && refCount != 2'h2)
						refCount <= refCount + 2'h1;
					if (modeValid && refCount == 2'(MIN_REFRESH))
						initState <= INIT_READY;
				end
				INIT_READY: initState <= INIT_READY;
				default: initState <= INIT_WAIT_PALL;
			endcase
		end
	end
	assign initDone = initState == INIT_READY;

	always_ff @(posedge clk) begin
		if (sys_rst)
			cmdIllegal <= 1'b0;
		else
			cmdIllegal <= (modeCmd && !allIdle)
				|| (rwCmd && bankIdle[addr[ADDR_BANK]])
				|| (actCmd && !bankIdle[addr[ADDR_BANK]])
				|| (strictInit && !initDone && (rwCmd || actCmd));
	end

	////////////////////////////////////////////////////////////////////////
	// wishbone registers
	logic wbReq;
	assign wbReq = wb_cyc_i && wb_stb_i;
	always_ff @(posedge clk) begin
		if (sys_rst)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= wbReq && !wb_ack_o;
	end
	always_ff @(posedge clk) begin
		if (sys_rst)
			strictInit <= CTRL_RST;
		else if (wbReq && !wb_ack_o && wb_we_i && wb_adr_i == REG_CTRL && wb_sel_i[0])
			strictInit <= wb_dat_i[0];
	end
	always_ff @(posedge clk) begin
		if (sys_rst)
			wb_dat_o <= 32'h00000000;
		else if (wbReq && !wb_ack_o)
			case (wb_adr_i)
				REG_STATUS: wb_dat_o <= {6'h00, bankState[1], bankState[0], initDone, modeValid, opcode};
				REG_CTRL: wb_dat_o <= {31'h00000000, strictInit};
				default: wb_dat_o <= 32'h00000000;
			endcase
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	sequence s_rd_lat2;
		rdCmd && latCode == LAT_2;
	endsequence
	sequence s_rd_lat3;
		rdCmd && latCode == LAT_3;
	endsequence
	sequence s_rd_pair;
		rdCmd && blCode == BL_2 && !bankIdle[addr[ADDR_BANK]] ##1 !cmdOn;
	endsequence

	a_mode_capture: assert property (@(posedge clk) disable iff (sys_rst)
		modeCmd && allIdle |=> opcode == $past(addr)) else $error("mode code not captured");
	a_mode_hold: assert property (@(posedge clk) disable iff (sys_rst)
		!modeCmd |=> $stable(opcode)) else $error("mode code changed without load");
	a_read_lat_two: assert property (@(posedge clk) disable iff (sys_rst)
		s_rd_lat2 ##2 latCode == LAT_2 |-> dqOe) else $error("read data late at latency two");
	a_read_lat_three: assert property (@(posedge clk) disable iff (sys_rst)
		s_rd_lat3 ##2 !dqOe ##1 latCode == LAT_3 |-> dqOe) else $error("read data wrong at latency three");
	a_col_bank: assert property (@(posedge clk) disable iff (sys_rst)
		rwCmd |=> memBank == $past(addr[ADDR_BANK]) && memCol == $past(addr[COL_W-1:0]))
		else $error("start column or bank wrong");
	a_write_first: assert property (@(posedge clk) disable iff (sys_rst)
		wrCmd |=> memWrite && memWdata == $past(dqIn)) else $error("first write data not taken");
	a_single_write: assert property (@(posedge clk) disable iff (sys_rst)
		wrCmd && singleWrite |=> !burstActive ##1 (!memWrite || $past(rwCmd))) else $error("single write bursted");
	a_pair_order: assert property (@(posedge clk) disable iff (sys_rst)
		s_rd_pair |=> memCol[0] != $past(memCol[0]) && memRead) else $error("second burst column wrong");
	a_bank_active: assert property (@(posedge clk) disable iff (sys_rst)
		actCmd && bankIdle[0] && !addr[ADDR_BANK] |=> bankState[0] == BANK_ACTIVE)
		else $error("bank not opened");
	a_ap_close: assert property (@(posedge clk) disable iff (sys_rst)
		rwCmd && addr[ADDR_AP] && lastNow && !bankIdle[addr[ADDR_BANK]] |=> bankIdle[$past(addr[ADDR_BANK])])
		else $error("auto precharge did not close bank");
endmodule : smri_sdram_mode
`default_nettype wire

// file: testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
	import smri_pkg::*;
;
	typedef struct packed {logic [11:0] op; logic wr; logic [11:0] a;} smri_row_t;
	localparam smri_row_t ROWS [6] = '{
		'{12'h022, 1'b1, 12'h306},
		'{12'h03B, 1'b0, 12'hA2D},
		'{12'h021, 1'b0, 12'h5FF},
		'{12'h030, 1'b1, 12'hC10},
		'{12'h223, 1'b1, 12'h333},
		'{12'h037, 1'b0, 12'h8FE}
	};
	logic clk, sysRst, cke, csN, rasN, casN, weN, dqOe, memRead, memWrite, memBank;
	logic initDone, cmdIllegal, wbCyc, wbStb, wbWe, wbAck;
	logic [1:0] dqm, memByteEn;
	logic [11:0] addr;
	logic [15:0] dqIn, dqOut, memWdata, memRdata;
	logic [10:0] memRow;
	logic [7:0] memCol;
	logic [3:0] wbAdr, wbSel;
	logic [31:0] wbDatI, wbDatO, q;
	int nFail = 0;
	int checks = 0;
	// storage array: data names its own bank and column
	assign memRdata = {4'h5, 3'h0, memBank, memCol};
	smri_ctrl_model u_ctrl (.clk(clk), .cke(cke), .csN(csN), .rasN(rasN), .casN(casN), .weN(weN), .dqm(dqm),
		.addr(addr), .dqIn(dqIn));
	smri_sdram_mode u_dut (.clk(clk), .sys_rst(sysRst), .cke(cke), .csN(csN), .rasN(rasN), .casN(casN),
		.weN(weN), .dqm(dqm), .addr(addr), .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe), .memRead(memRead),
		.memWrite(memWrite), .memBank(memBank), .memRow(memRow), .memCol(memCol), .memWdata(memWdata),
		.memByteEn(memByteEn), .memRdata(memRdata), .initDone(initDone), .cmdIllegal(cmdIllegal),
		.wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
		.wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck));
	////////////////////////////////////////////////////////////
	task automatic endSim();
		if (nFail == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : endSim
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			nFail++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic wbXfer(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		{wbCyc, wbStb, wbWe, wbAdr, wbSel, wbDatI} <= {2'h3, w, a, 4'hF, d};
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (wbAck !== 1'b1 && n < 20);
		if (wbAck !== 1'b1) begin
			nFail++;
			endSim();
		end
		q = wbDatO;
		{wbCyc, wbStb} <= 2'h0;
	endtask : wbXfer
	function automatic int expLen(logic [11:0] op, logic wr);
		if (wr && op[11:9] == WM_SINGLE) return 1;
		case (op[2:0])
			BL_2: return 2;
			BL_4: return 4;
			BL_8: return 8;
			BL_PAGE: return 256;
			default: return 1;
		endcase
	endfunction : expLen
	function automatic logic [7:0] expCol(logic [11:0] op, logic [7:0] c, int i);
		logic [7:0] m;
		m = 8'(expLen(op, 1'b0) - 1);
		if (op[3] && op[2:0] != BL_PAGE) return (c & ~m) | ((c ^ 8'(i)) & m);
		return (c & ~m) | ((c + 8'(i)) & m);
	endfunction : expCol
	task automatic runRow(input smri_row_t r);
		int len;
		int lat;
		u_ctrl.issue(CMD_PRE, 12'h400);
		u_ctrl.load(r.op);
		wbXfer(1'b0, REG_STATUS, 32'h0);
		check("opcode", {20'h0, q[11:0]}, {20'h0, r.op});
		u_ctrl.issue(CMD_ACT, {r.a[11], 11'h055});
		u_ctrl.issue(r.wr ? CMD_WRITE : CMD_READ, r.a);
		len = expLen(r.op, r.wr);
		lat = (r.op[6:4] == LAT_3) ? 3 : 2;
		for (int k = 0; k <= len + lat; k++) begin
			#1;
			if (k < len) begin
				check("strobe", {31'h0, r.wr ? memWrite : memRead}, 32'h1);
				check("col", {24'h0, memCol}, {24'h0, expCol(r.op, r.a[7:0], k)});
				check("bank", {31'h0, memBank}, {31'h0, r.a[11]});
				check("row", {21'h0, memRow}, {21'h0, 11'h055});
				if (r.wr) check("byteEn", {30'h0, memByteEn}, 32'h3);
				if (r.wr) check("wdata", {16'h0, memWdata}, {16'h0, dqIn - 16'h0001});
			end else if (k == len) check("end", {31'h0, memWrite | memRead}, 32'h0);
			if (!r.wr && k >= lat - 1 && k < len + lat - 1)
				check("rdata", {15'h0, dqOe, dqOut}, {16'h1, 4'h5, 3'h0, r.a[11], expCol(r.op, r.a[7:0], k - lat + 1)});
			@(posedge clk);
		end
		if (len == 256) u_ctrl.issue(CMD_STOP, 12'h000);
		wbXfer(1'b0, REG_STATUS, 32'h0);
		check("bankState", {26'h0, r.a[11] ? q[25:20] : q[19:14]}, {26'h0, r.a[10] ? BANK_IDLE : BANK_ACTIVE});
	endtask : runRow
	////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		{sysRst, wbCyc, wbStb, wbWe, wbAdr, wbSel, wbDatI} = {4'h8, 4'h0, 4'h0, 32'h0};
		repeat (6) @(posedge clk);
		sysRst <= 1'b0;
		wbXfer(1'b0, REG_STATUS, 32'h0);
		check("status", q, 32'h00104000);
		u_ctrl.init(1'b0, 12'h022);
		repeat (2) @(posedge clk);
		#1;
		check("initDone", {31'h0, initDone}, 32'h1);
		foreach (ROWS[i]) runRow(ROWS[i]);
		u_ctrl.issue(CMD_PRE, 12'h400);
		u_ctrl.issue(CMD_ACT, 12'h055);
		u_ctrl.issue(CMD_MODE, 12'h033);
		#1;
		check("illegal", {31'h0, cmdIllegal}, 32'h1);
		wbXfer(1'b0, REG_STATUS, 32'h0);
		check("kept", {20'h0, q[11:0]}, 32'h037);
		wbXfer(1'b0, 4'h8, 32'h0);
		check("unmapped", q, 32'h0);
		wbXfer(1'b1, REG_CTRL, 32'h1);
		wbXfer(1'b0, REG_CTRL, 32'h0);
		check("ctrl", {31'h0, q[0]}, 32'h1);
		sysRst <= 1'b1;
		repeat (6) @(posedge clk);
		sysRst <= 1'b0;
		@(posedge clk);
		#1;
		check("rstDone", {31'h0, initDone}, 32'h0);
		wbXfer(1'b1, REG_CTRL, 32'h1);
		u_ctrl.issue(CMD_ACT, 12'h055);
		#1;
		check("strict", {31'h0, cmdIllegal}, 32'h1);
		u_ctrl.init(1'b1, 12'h021);
		repeat (2) @(posedge clk);
		#1;
		check("initMode", {31'h0, initDone}, 32'h1);
		endSim();
	end
endmodule : testbench
`default_nettype wire
